// file: rtl/issf_status_flags.sv
// Slave status, error and request flag logic with APB access
`timescale 1ns/1ps

// Summary of operation
// - Start flag set on matched address, general call, high-speed or start byte.
// - Start flag clears on any later start or stop condition.
// - Repeated-start flag set on start while start flag set; read or stop clear.
// - Two-bit field reports which of four ID registers matched.
// - Stop flag set on stop after matched start; status read clears it.
// - Stop flag raises the interrupt when stop interrupt enable is set.
// - General call kind: none, reset+program, program, hardware call.
// - General call kind cleared only by general call clear write.
// - General call flag set on any general call accepted by the general call accept bit; always interrupts.
// - General call reset returns control register and NACK, overflow, request flags to defaults.
// - Hardware call second byte is acknowledged and left for the receive FIFO.
// - Active flag set on start; cleared on mismatch or stop.
// - NACK flag on empty slave read or NACK-next while addressed.
// - Overflow flag set when pushing into a full receive FIFO.
// - Receive request high while receive FIFO holds data.
// - Receive request first rises on falling edge of last data bit.
// - Transmit request set on read direction; cleared by status read or full FIFO.
// - Early mode off: falling edge of direction bit; on: after rising edge.
// - Status resets to 0x0001; top bit always reads zero.
// - Early mode raises transmit request just after direction bit rising edge.
// - General call clear write clears flag and kind; bit is not stored.
// - Slave enable low holds slave state and flags, except general call flag and kind, in reset.
// - NACK-next answers the next addressed communication with not-acknowledge.
module issf_status_flags
  import issf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  clkEn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // I2C pins
  input  wire logic                  sclIn,
  input  wire logic                  sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOe,
  // Data path status
  input  wire issf_pkg::issf_fifo_t  fifoSt,
  input  wire issf_pkg::issf_ids_t   idVals,
  // Interrupt
  output logic                       slaveIrq
);
  import issf_pkg::*;

  // Pin synchronisers and filtered levels
  logic [2:0]  sclSync_ff;
  logic [2:0]  sdaSync_ff;
  logic        sclLvl_ff;
  logic        sdaLvl_ff;
  logic        sclRise;
  logic        sclFall;
  logic        startSeen;
  logic        stopSeen;

  // Control and bus
  logic [6:0]  ctrl_ff;
  logic        slvRst;
  logic        accDone;
  logic        rdStatus;
  logic        wrCtrl;
  logic        hitStatus;
  logic        hitCtrl;
  logic [15:0] statusWord;
  logic [15:0] rdMask_ff;
  logic [15:0] clrMask;
  logic        gcClear;

  // Bit engine
  issf_phase_t phase_ff;
  logic [3:0]  bitCnt_ff;
  logic [6:0]  shift_ff;
  logic [7:0]  byteNow;
  logic        addressed_ff;
  logic        readDir_ff;
  logic        gcCall_ff;
  logic [1:0]  gcKindNxt_ff;
  logic        rise8;
  logic        fall8;
  logic        fallAck;
  logic [3:0]  idHit;
  logic        anyId;
  logic        gcHit;
  logic        hsHit;
  logic        sbHit;
  logic        gcReset;

  // Flags
  logic        start_ff;
  logic        rep_ff;
  logic [1:0]  idx_ff;
  logic        stop_ff;
  logic [1:0]  kind_ff;
  logic        gc_ff;
  logic        busy_ff;
  logic        nack_ff;
  logic        rxof_ff;
  logic        rxreq_ff;
  logic        txreq_ff;
  logic        txstat_ff;

  // Change counts once second and third stages agree
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sclSync_ff <= 3'h7;
      sdaSync_ff <= 3'h7;
      sclLvl_ff  <= 1'h1;
      sdaLvl_ff  <= 1'h1;
    end
    else if (clkEn)
    begin
      sclSync_ff <= {sclSync_ff[1:0], sclIn};
      sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
      if (sclSync_ff[1] == sclSync_ff[2])
        sclLvl_ff <= sclSync_ff[2];
      if (sdaSync_ff[1] == sdaSync_ff[2])
        sdaLvl_ff <= sdaSync_ff[2];
    end
  end

  assign sclRise   = sclSync_ff[1] & sclSync_ff[2] & ~sclLvl_ff;
  assign sclFall   = ~sclSync_ff[1] & ~sclSync_ff[2] & sclLvl_ff;
  assign startSeen = sclLvl_ff & sdaLvl_ff & ~sdaSync_ff[1] & ~sdaSync_ff[2];
  assign stopSeen  = sclLvl_ff & ~sdaLvl_ff & sdaSync_ff[1] & sdaSync_ff[2];

  // APB decode; one wait state per access
  assign hitStatus = (paddr == ISSF_STATUS_ADDR);
  assign hitCtrl   = (paddr == ISSF_CTRL_ADDR);
  assign accDone   = psel & penable & pready;
  assign rdStatus  = accDone & ~pwrite & hitStatus;
  assign wrCtrl    = accDone & pwrite & hitCtrl;
  assign gcClear   = wrCtrl & pwdata[ISSF_C_GC_CLEAR];
  assign clrMask   = rdStatus ? rdMask_ff : 16'h0000;
  assign slvRst    = reset | ~ctrl_ff[ISSF_C_SLAVE_ON];

  assign statusWord = {1'b0, start_ff, rep_ff, idx_ff, stop_ff, kind_ff,
                       gc_ff, busy_ff, nack_ff, rxof_ff, rxreq_ff,
                       txreq_ff, 1'b0, txstat_ff};

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
      rdMask_ff <= 16'h0000;
    end
    else if (clkEn)
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hitStatus & ~hitCtrl;
      if (psel & penable & ~pready)
      begin
        // Only bits reported to software may be cleared by this read
        rdMask_ff <= statusWord;
        if (hitStatus)
          prdata <= {16'h0000, statusWord};
        else if (hitCtrl)
          prdata <= {25'h0000000, ctrl_ff};
        else
          prdata <= 32'h00000000;
      end
    end
  end

  // Control register; clear bit is write-only
  always_ff @(posedge sys_clk)
  begin
    if (reset | gcReset)
      ctrl_ff <= ISSF_CTRL_RST;
    else if (clkEn)
    begin
      if (wrCtrl)
      begin
        ctrl_ff <= pwdata[6:0];
        ctrl_ff[ISSF_C_GC_CLEAR] <= 1'b0;
      end
      else if (fall8 & (phase_ff == PH_ADDR) & addressed_ff)
        ctrl_ff[ISSF_C_NACK_NEXT] <= 1'b0;
    end
  end

  // Address byte decode
  assign byteNow = {shift_ff, sdaLvl_ff};
  assign rise8   = sclRise & (bitCnt_ff == ISSF_BIT_LAST - 4'h1);
  assign fall8   = sclFall & (bitCnt_ff == ISSF_BIT_LAST);
  assign fallAck = sclFall & (bitCnt_ff == ISSF_BIT_ACK);

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      idHit[i] = (shift_ff == idVals.id[i][7:1]);
  end

  assign anyId = |idHit;
  assign gcHit = (byteNow == {ISSF_GC_ADDR, 1'b0})
                 & ctrl_ff[ISSF_C_GC_ACCEPT];
  assign hsHit = (byteNow[7:3] == ISSF_HS_PREFIX);
  assign sbHit = (byteNow == {ISSF_GC_ADDR, 1'b1});
  assign gcReset = fall8 & (phase_ff == PH_GC2)
                   & (gcKindNxt_ff == ISSF_KIND_RESET);

  // Bit counting and transfer phase
  always_ff @(posedge sys_clk)
  begin
    if (slvRst)
    begin
      phase_ff     <= PH_IDLE;
      bitCnt_ff    <= 4'h0;
      shift_ff     <= 7'h00;
      addressed_ff <= 1'b0;
      readDir_ff   <= 1'b0;
      gcCall_ff    <= 1'b0;
      gcKindNxt_ff <= ISSF_KIND_NONE;
      sdaOe        <= 1'b0;
    end
    else if (clkEn)
    begin
      if (startSeen)
      begin
        phase_ff  <= PH_ADDR;
        bitCnt_ff <= 4'h0;
        sdaOe     <= 1'b0;
      end
      else if (stopSeen)
      begin
        phase_ff <= PH_IDLE;
        sdaOe    <= 1'b0;
      end
      else
      begin
        if (sclRise & (bitCnt_ff < ISSF_BIT_ACK))
        begin
          shift_ff  <= byteNow[6:0];
          bitCnt_ff <= bitCnt_ff + 4'h1;
        end
        if (rise8 & (phase_ff == PH_ADDR))
        begin
          addressed_ff <= anyId | gcHit;
          readDir_ff   <= sdaLvl_ff;
          gcCall_ff    <= gcHit;
        end
        if (rise8 & (phase_ff == PH_GC2))
        begin
          if (byteNow == ISSF_GC_RESET)
            gcKindNxt_ff <= ISSF_KIND_RESET;
          else if (byteNow == ISSF_GC_PROG)
            gcKindNxt_ff <= ISSF_KIND_PROG;
          else if (ctrl_ff[ISSF_C_HWGC_EN] & (byteNow == idVals.alt))
            gcKindNxt_ff <= ISSF_KIND_HW;
          else
            gcKindNxt_ff <= ISSF_KIND_NONE;
        end
        if (fall8)
        begin
          unique case (phase_ff)
            PH_ADDR:
            begin
              sdaOe <= addressed_ff & ~ctrl_ff[ISSF_C_NACK_NEXT]
                       & ~(readDir_ff & fifoSt.txEmpty);
              if (~addressed_ff)
                phase_ff <= PH_IDLE;
              else if (gcCall_ff)
                phase_ff <= PH_GC2;
              else if (readDir_ff)
                phase_ff <= PH_TXDATA;
              else
                phase_ff <= PH_RXDATA;
            end
            PH_GC2:
            begin
              sdaOe    <= 1'b1;
              phase_ff <= PH_RXDATA;
            end
            PH_RXDATA: sdaOe <= 1'b1;
            PH_TXDATA: sdaOe <= 1'b0;
            PH_IDLE:   sdaOe <= 1'b0;
          endcase
        end
        if (fallAck)
        begin
          bitCnt_ff <= 4'h0;
          sdaOe     <= 1'b0;
        end
      end
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sdaOut <= 1'b0;
    else if (clkEn)
      sdaOut <= 1'b0;
  end

  // Start, repeated start, stop, match index, active
  always_ff @(posedge sys_clk)
  begin
    if (slvRst)
    begin
      start_ff <= 1'b0;
      rep_ff   <= 1'b0;
      stop_ff  <= 1'b0;
      idx_ff   <= 2'h0;
      busy_ff  <= 1'b0;
    end
    else if (clkEn)
    begin
      if (startSeen | stopSeen)
        start_ff <= 1'b0;
      else if (rise8 & (phase_ff == PH_ADDR)
               & (anyId | gcHit | hsHit | sbHit))
        start_ff <= 1'b1;
      if (startSeen & start_ff)
        rep_ff <= 1'b1;
      else if (stopSeen | clrMask[ISSF_S_REP])
        rep_ff <= 1'b0;
      if (stopSeen & start_ff & addressed_ff)
        stop_ff <= 1'b1;
      else if (clrMask[ISSF_S_STOP])
        stop_ff <= 1'b0;
      if (rise8 & (phase_ff == PH_ADDR) & anyId)
      begin
        for (int i = 3; i >= 0; i--)
          if (idHit[i])
            idx_ff <= 2'(i);
      end
      if (startSeen)
        busy_ff <= 1'b1;
      else if (stopSeen)
        busy_ff <= 1'b0;
      else if (rise8 & (phase_ff == PH_ADDR) & ~anyId & ~gcHit)
        busy_ff <= 1'b0;
    end
  end

  // General call fields survive slave disable and call reset
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      kind_ff <= ISSF_KIND_NONE;
      gc_ff   <= 1'b0;
    end
    else if (clkEn)
    begin
      if (fall8 & (phase_ff == PH_GC2))
      begin
        kind_ff <= gcKindNxt_ff;
        gc_ff   <= 1'b1;
      end
      else if (gcClear)
      begin
        kind_ff <= ISSF_KIND_NONE;
        gc_ff   <= 1'b0;
      end
    end
  end

  // NACK, overflow, receive and transmit requests
  always_ff @(posedge sys_clk)
  begin
    if (slvRst | gcReset)
    begin
      nack_ff   <= 1'b0;
      rxof_ff   <= 1'b0;
      rxreq_ff  <= 1'b0;
      txreq_ff  <= 1'b0;
      txstat_ff <= ISSF_STATUS_RST[ISSF_S_TXSTAT];
    end
    else if (clkEn)
    begin
      txstat_ff <= fifoSt.txEmpty;
      if (fall8 & (phase_ff == PH_ADDR) & addressed_ff
          & (ctrl_ff[ISSF_C_NACK_NEXT]
             | (readDir_ff & fifoSt.txEmpty)))
        nack_ff <= 1'b1;
      else if (clrMask[ISSF_S_NACK])
        nack_ff <= 1'b0;
      if (fifoSt.rxPush & fifoSt.rxFull)
        rxof_ff <= 1'b1;
      else if (clrMask[ISSF_S_RXOF])
        rxof_ff <= 1'b0;
      // Level follows FIFO contents once the first byte is in
      rxreq_ff <= (fall8 & (phase_ff == PH_RXDATA))
                  | fifoSt.rxNotEmpty;
      if (ctrl_ff[ISSF_C_EARLY_TX] & rise8 & (phase_ff == PH_ADDR)
          & anyId & sdaLvl_ff)
        txreq_ff <= 1'b1;
      else if (~ctrl_ff[ISSF_C_EARLY_TX] & fall8
               & (phase_ff == PH_ADDR) & addressed_ff & readDir_ff)
        txreq_ff <= 1'b1;
      else if (clrMask[ISSF_S_TXREQ])
        txreq_ff <= 1'b0;
      else if (~fifoSt.txNotFull)
        txreq_ff <= 1'b0;
    end
  end

  // Interrupt request
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      slaveIrq <= 1'b0;
    else if (clkEn)
      slaveIrq <= (stop_ff & ctrl_ff[ISSF_C_STOP_IEN])
                  | gc_ff;
  end

endmodule : issf_status_flags

// file: rtl/issf_pkg.sv
// Shared constants and types for the slave status flag block
package issf_pkg;

  // Register byte addresses
  localparam logic [31:0] ISSF_STATUS_ADDR = 32'h4000342c;
  localparam logic [31:0] ISSF_CTRL_ADDR   = 32'h40003450;

  // Reset values
  localparam logic [15:0] ISSF_STATUS_RST = 16'h0001;
  localparam logic [6:0]  ISSF_CTRL_RST   = 7'h00;

  // Control register field positions
  localparam int ISSF_C_SLAVE_ON   = 0;
  localparam int ISSF_C_STOP_IEN   = 1;
  localparam int ISSF_C_GC_ACCEPT  = 2;
  localparam int ISSF_C_HWGC_EN    = 3;
  localparam int ISSF_C_GC_CLEAR   = 4;
  localparam int ISSF_C_EARLY_TX   = 5;
  localparam int ISSF_C_NACK_NEXT  = 6;

  // Status register field positions
  localparam int ISSF_S_START   = 14;
  localparam int ISSF_S_REP     = 13;
  localparam int ISSF_S_IDX_LO  = 11;
  localparam int ISSF_S_STOP    = 10;
  localparam int ISSF_S_KIND_LO = 8;
  localparam int ISSF_S_GC      = 7;
  localparam int ISSF_S_BUSY    = 6;
  localparam int ISSF_S_NACK    = 5;
  localparam int ISSF_S_RXOF    = 4;
  localparam int ISSF_S_RXREQ   = 3;
  localparam int ISSF_S_TXREQ   = 2;
  localparam int ISSF_S_TXSTAT  = 0;

  // Bit counter marks: eighth bit and acknowledge bit
  localparam logic [3:0] ISSF_BIT_LAST = 4'h8;
  localparam logic [3:0] ISSF_BIT_ACK  = 4'h9;

  // Address byte and general call second byte codes
  localparam logic [6:0] ISSF_GC_ADDR   = 7'h00;
  localparam logic [4:0] ISSF_HS_PREFIX = 5'h01;
  localparam logic [7:0] ISSF_GC_RESET  = 8'h06;
  localparam logic [7:0] ISSF_GC_PROG   = 8'h04;

  // General call kinds
  localparam logic [1:0] ISSF_KIND_NONE  = 2'h0;
  localparam logic [1:0] ISSF_KIND_RESET = 2'h1;
  localparam logic [1:0] ISSF_KIND_PROG  = 2'h2;
  localparam logic [1:0] ISSF_KIND_HW    = 2'h3;

  typedef enum {PH_IDLE, PH_ADDR, PH_GC2, PH_RXDATA, PH_TXDATA} issf_phase_t;

  // FIFO status from the data path
  typedef struct packed {
    logic rxNotEmpty;
    logic rxFull;
    logic rxPush;
    logic txNotFull;
    logic txEmpty;
  } issf_fifo_t;

  // Slave ID and alternative ID values
  typedef struct packed {
    logic [3:0][7:0] id;
    logic [7:0]      alt;
  } issf_ids_t;

endpackage : issf_pkg

// file: tb/issf_checker.sv
// Port-level assertions for the slave status flag block
`timescale 1ns/1ps
module issf_checker
  import issf_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // I2C pins and interrupt
  input wire logic        sclIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        slaveIrq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic mapped;
  assign mapped = (paddr == ISSF_STATUS_ADDR) || (paddr == ISSF_CTRL_ADDR);
  sequence s_taken;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_one_wait: assert property (s_taken |=> s_answer)
    else $error("ready not a single pulse after one wait");
  a_no_stray: assert property (!(psel && penable) |=> !pready)
    else $error("ready without an access");
  a_unmapped_err: assert property (pready && !mapped |-> pslverr
    && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && mapped |-> !pslverr)
    else $error("error on a mapped register");
  a_status_zero: assert property (pready && !pwrite
    && paddr == ISSF_STATUS_ADDR |-> prdata[31:15] == 17'h0
    && prdata[1] == 1'h0)
    else $error("reserved status bits not zero");
  a_clear_unheld: assert property (pready && !pwrite
    && paddr == ISSF_CTRL_ADDR |-> prdata[31:7] == 25'h0
    && prdata[4] == 1'h0)
    else $error("clear bit or upper control bits read back");
  a_sda_drain: assert property (sdaOut == 1'h0)
    else $error("data pin driven high");
  // Only the low phase may move the acknowledge; sync delay is 3 cycles
  a_sda_steady: assert property (sclIn && $past(sclIn, 3)
    |-> $stable(sdaOe))
    else $error("data changed while clock high");
  a_irq_clears: assert property ($fell(slaveIrq)
    |-> $past(pready, 2))
    else $error("interrupt dropped without register access");
endmodule : issf_checker

bind issf_status_flags issf_checker chk (.sys_clk(sys_clk),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .slaveIrq(slaveIrq));

// file: tb/issf_i2c_master.sv
// Behavioural I2C bus master on the far side of the link
`timescale 1ns/1ps
module issf_i2c_master
(
  // Clock
  input  wire logic sys_clk,
  // Bus lines
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaOe
);
  initial
  begin
    scl = 1'h1;
    sdaOe = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // Data moves a cycle after the fall, never beside a clock edge
  task automatic clockBit(input logic b, output logic seen);
    tick(1);
    sdaOe <= !b;
    tick(3);
    scl <= 1'h1;
    tick(4);
    seen = sdaLine;
    scl <= 1'h0;
  endtask : clockBit
  // Serves as first and repeated start alike
  task automatic start();
    tick(1);
    sdaOe <= 1'h0;
    tick(3);
    scl <= 1'h1;
    tick(4);
    sdaOe <= 1'h1;
    tick(4);
    scl <= 1'h0;
  endtask : start
  task automatic stop();
    tick(1);
    sdaOe <= 1'h1;
    tick(3);
    scl <= 1'h1;
    tick(4);
    sdaOe <= 1'h0;
    tick(4);
  endtask : stop
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clockBit(b[i], s);
    clockBit(1'h1, s);
    ack = !s;
  endtask : sendByte
endmodule : issf_i2c_master

// file: tb/tb.sv
// Testbench: APB register access and I2C traffic for the flag block
`timescale 1ns/1ps
module tb;
  import issf_pkg::*;
  localparam logic [31:0] ST = ISSF_STATUS_ADDR;
  localparam logic [31:0] CT = ISSF_CTRL_ADDR;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic        sys_clk = 1'h0;
  logic        reset = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, sdaOut, sdaOe, slaveIrq;
  logic        scl, mOe, sdaLine, ack, err;
  logic [31:0] rdat;
  issf_fifo_t  fifoSt = 5'h03;
  issf_ids_t   idVals = {8'h72, 8'h60, 8'h50, 8'h20, 8'h33};
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #10 sys_clk = ~sys_clk;
  assign sdaLine = !(mOe || sdaOe);
  issf_status_flags dut (.sys_clk(sys_clk), .reset(reset),
    .clkEn(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .fifoSt(fifoSt), .idVals(idVals),
    .slaveIrq(slaveIrq));
  issf_i2c_master m (.sys_clk(sys_clk), .sdaLine(sdaLine), .scl(scl),
    .sdaOe(mOe));
  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s got %h", $time, msg, got);
    end
  endtask : chk
  // Request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [31:0] a, d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk iff pready === 1'h1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  task automatic rd(input logic [31:0] a, exp, mask, input string msg);
    xfer(1'h0, a, 32'h0);
    chk(rdat & mask, exp, msg);
  endtask : rd
  task automatic waitIrq(input logic v);
    int n;
    n = 0;
    while (slaveIrq !== v && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(slaveIrq, v, "interrupt level");
  endtask : waitIrq
  task automatic t_reset();
    rd(ST, 32'h0001, ALL, "status reset");
    rd(CT, 32'h0, ALL, "control reset");
    rd(32'h40003400, 32'h0, ALL, "unmapped data");
    chk(err, 1'h1, "unmapped error");
  endtask : t_reset
  task automatic t_write_rx();
    xfer(1'h1, CT, 32'h3);
    m.start();
    m.sendByte(8'h50, ack);
    chk(ack, 1'h1, "address ack");
    rd(ST, 32'h4841, ALL, "addressed");
    fifoSt.rxNotEmpty <= 1'h1;
    m.sendByte(8'ha5, ack);
    fifoSt.rxFull <= 1'h1;
    fifoSt.rxPush <= 1'h1;
    @(posedge sys_clk);
    fifoSt.rxPush <= 1'h0;
    m.stop();
    waitIrq(1'h1);
    rd(ST, 32'h0c19, ALL, "after stop");
    rd(ST, 32'h0809, ALL, "read cleared");
    waitIrq(1'h0);
    fifoSt <= 5'h03;
    rd(ST, 32'h0801, ALL, "rx drained");
  endtask : t_write_rx
  task automatic t_rep_read();
    fifoSt <= 5'h02;
    m.start();
    m.sendByte(8'h50, ack);
    m.start();
    m.sendByte(8'h51, ack);
    rd(ST, 32'h6844, ALL, "repeated read");
    rd(ST, 32'h4840, ALL, "tx request read");
    m.stop();
    rd(ST, 32'h0c00, ALL, "read stop");
    m.start();
    m.sendByte(8'h44, ack);
    chk(ack, 1'h0, "foreign ack");
    rd(ST, 32'h0800, ALL, "foreign addr");
    m.stop();
    rd(ST, 32'h0800, ALL, "foreign stop");
    // Early mode must also raise the transmit request
    xfer(1'h1, CT, 32'h23);
    m.start();
    m.sendByte(8'h51, ack);
    rd(ST, 32'h4, 32'h4, "early tx request");
    m.stop();
  endtask : t_rep_read
  task automatic t_nack();
    xfer(1'h1, CT, 32'h43);
    m.start();
    m.sendByte(8'h50, ack);
    chk(ack, 1'h0, "nack next");
    rd(ST, 32'h20, 32'h20, "nack flag");
    m.stop();
    fifoSt <= 5'h03;
    m.start();
    m.sendByte(8'h51, ack);
    chk(ack, 1'h0, "empty read ack");
    rd(ST, 32'h20, 32'h20, "empty read flag");
    m.stop();
    for (int i = 0; i < 2; i++)
    begin
      m.start();
      m.sendByte(i ? 8'h01 : 8'h08, ack);
      rd(ST, 32'h4000, 32'h4000, "special code");
      m.stop();
    end
  endtask : t_nack
  task automatic t_gcall();
    logic [7:0]  sec [3] = '{8'h04, 8'h33, 8'h06};
    logic [31:0] kind [3] = '{32'h280, 32'h380, 32'h180};
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'h1, CT, 32'h1f);
      rd(ST, 32'h0, 32'h380, "gc cleared");
      m.start();
      m.sendByte(8'h00, ack);
      m.sendByte(sec[i], ack);
      rd(ST, kind[i], 32'h380, "gc kind");
      waitIrq(1'h1);
      m.stop();
    end
    rd(CT, 32'h0, ALL, "gc reset control");
    rd(ST, 32'h180, 32'h380, "kind kept");
    xfer(1'h1, CT, 32'h10);
    rd(CT, 32'h0, ALL, "clear not stored");
    rd(ST, 32'h0, 32'h380, "gc clear");
    waitIrq(1'h0);
    m.start();
    m.sendByte(8'h50, ack);
    chk(ack, 1'h0, "slave off ack");
    rd(ST, 32'h0001, ALL, "slave off");
    m.stop();
  endtask : t_gcall
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'h0;
    t_reset();
    t_write_rx();
    t_rep_read();
    t_nack();
    t_gcall();
    finish_test();
  end
endmodule : tb
